//--- rtl/iso_ctrl_cfg.svh
// Offsets, field positions, reset values and timing counts of the iso buffer control.
// Assumes a 25 MHz pclk and an APB slave with 32-bit data.
`ifndef ISO_CTRL_CFG_SVH
`define ISO_CTRL_CFG_SVH

// ----------------------------------------
// Register byte addresses on APB
// ----------------------------------------
`define OFF_FAST_XFR 12'h000
`define OFF_ISO_CTRL 12'h004
`define OFF_ZERO_CNT 12'h008
`define OFF_PAIRING 12'h00c
`define OFF_STATUS 12'h010

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define FX_FAST_ISO 7
`define FX_FAST_BULK 6
`define FX_READ_STROBE_POLARITY 5
`define FX_WRITE_STROBE_POLARITY 2
`define IC_DISABLE 0
`define IC_PINGPONG 3
`define PR_SEND_EMPTY 7
`define FAST_XFR_RST 8'h00
`define ISO_CTRL_RST 8'h00
`define PAIRING_RST 8'h00

// ----------------------------------------
// Memory windows
// ----------------------------------------
`define ISO_RAM_LO 16'h2000
`define ISO_RAM_HI 16'h27ff
`define STRB_LO_ON 16'h2000
`define STRB_LO_OFF 16'h2800
`define STRB_LO_END 16'h7b40
`define STRB_HI_LO 16'h8000

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_MHZ 25
`define SWAP_LEAD_US 10
`define SWAP_LEAD_CYC ((`SWAP_LEAD_US) * (`CLK_MHZ))

`endif

//--- rtl/iso_ctrl_pkg.sv
// Types shared by the iso buffer control.
// Assumes the _cfg header for numeric constants.
package iso_ctrl_pkg;
    typedef enum logic [1:0] {tok_idle, tok_wait, tok_zlp} token_e;
    typedef struct packed {
        logic valid;
        logic [2:0] ep;
    } ep_event_s;
    typedef struct packed {
        logic req;
        logic wr;
        logic [15:0] addr;
    } cpu_acc_s;
endpackage : iso_ctrl_pkg

//--- rtl/iso_buffer_control.sv
// Isochronous endpoint buffer control with APB registers.
// Assumes synchronous inputs on pclk; SOF, tokens and CPU accesses come from the core.
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "iso_ctrl_cfg.svh"

// What this block does
// - In fast mode each iso IN FIFO write loads one byte from external bus.
// - Iso-disable bit 0 disables all sixteen iso endpoints.
// - Iso-disable clears at reset; iso endpoints enabled by default.
// - While disabled, 2 KB iso RAM is data memory at 0x2000-0x27ff.
// - External strobes fire in 2000-7b40 and 8000-ffff; lower start 2800 when disabled.
// - Ping-pong bit 3 toggles every SOF; writes to it do nothing.
// - While disabled, the auto pointer cannot reach 0x2000-0x27ff.
// - Zero-count bit reads 1 when endpoint got no OUT bytes last frame.
// - All eight zero-count flags refresh once at every SOF.
// - Empty IN FIFO with send-empty 0: no response to IN token.
// - Empty IN FIFO with send-empty 1: answer zero-length packet.
// - One send-empty bit governs iso IN endpoints 8 to 15 together.
// - Each endpoint is a FIFO pair swapped at SOF.
// - Swap occurs about 10 us before the SOF interrupt.
// - Fast control fields: b7 iso, b6 bulk, b5 read_strobe_polarity, b4-3 rtim, b2 write_strobe_polarity, b1-0 wtim.
// - Fast mode routes iso FIFO accesses to external bus with strobes.
module iso_buffer_control
    import iso_ctrl_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sof,
    input wire ep_event_s out_byte,
    input wire ep_event_s in_token,
    input wire logic [7:0] in_fifo_empty,
    input wire cpu_acc_s cpu_acc,
    input wire logic cpu_iso_fifo,
    input wire logic cpu_in_fifo,
    input wire logic [7:0] cpu_acc_data,
    input wire logic [7:0] ext_data_in,
    input wire logic [15:0] auto_ptr_addr,
    output logic [7:0] fifo_wdata,
    output logic fifo_we,
    output logic [7:0] ext_data_out,
    output logic ext_data_oe,
    output logic fast_read_strobe,
    output logic fast_write_strobe,
    output logic ext_rd_strobe,
    output logic ext_wr_strobe,
    output logic iso_ram_as_data,
    output logic auto_ptr_blocked,
    output logic iso_disable,
    output logic pingpong_state,
    output logic fifo_swap,
    output logic sof_irq,
    output logic send_zlp,
    output logic [2:0] zlp_ep
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    localparam int SWAP_CYC = `SWAP_LEAD_CYC;
    logic [7:0] fast_transfer_control, endpoint_pairing_control, zero_count_out_flags, got_bytes;
    logic [8:0] lead_cnt;
    logic lead_busy, apb_wr, apb_rd, fast_iso, rd_pol, wr_pol, in_strobe_window;
    logic [31:0] next_prdata;
    token_e tok_state;
    default clocking cb_chk @(posedge pclk); endclocking
    default disable iff (!presetn);

    function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo, hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction : in_range
    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && !penable && !pwrite;
    assign fast_iso = fast_transfer_control[`FX_FAST_ISO];
    assign rd_pol = fast_transfer_control[`FX_READ_STROBE_POLARITY];
    assign wr_pol = fast_transfer_control[`FX_WRITE_STROBE_POLARITY];

    // ----------------------------------------
    // APB slave, zero wait states
    // ----------------------------------------
    // Read mux, zero on unmapped
    always_comb begin
        next_prdata = 32'h0000_0000;
        if (paddr == `OFF_FAST_XFR) begin
            next_prdata[7:0] = fast_transfer_control;
        end else if (paddr == `OFF_ISO_CTRL) begin
            next_prdata[`IC_DISABLE] = iso_disable;
            next_prdata[`IC_PINGPONG] = pingpong_state;
        end else if (paddr == `OFF_ZERO_CNT) begin
            next_prdata[7:0] = zero_count_out_flags;
        end else if (paddr == `OFF_PAIRING) begin
            next_prdata[7:0] = endpoint_pairing_control;
        end else if (paddr == `OFF_STATUS) begin
            next_prdata[0] = lead_busy;
        end
    end
    // Read data captured in setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (apb_rd) begin
            prdata <= next_prdata;
        end
    end
    // Always ready; error on unmapped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && (paddr > `OFF_STATUS || paddr[1:0] != 2'b00);
        end
    end
    // Control registers; zero-count not writable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fast_transfer_control <= `FAST_XFR_RST;
            endpoint_pairing_control <= `PAIRING_RST;
            iso_disable <= 1'(`ISO_CTRL_RST >> `IC_DISABLE);
        end else if (apb_wr) begin
            if (paddr == `OFF_FAST_XFR) begin
                fast_transfer_control <= pwdata[7:0];
            end else if (paddr == `OFF_ISO_CTRL) begin
                iso_disable <= pwdata[`IC_DISABLE];
            end else if (paddr == `OFF_PAIRING) begin
                endpoint_pairing_control <= pwdata[7:0];
            end
        end
    end

    // ----------------------------------------
    // Frame events
    // ----------------------------------------
    // Ping-pong toggles and FIFO pair swaps at SOF
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pingpong_state <= 1'b0;
            fifo_swap <= 1'b0;
        end else begin
            fifo_swap <= sof && !iso_disable;
            if (sof) begin
                pingpong_state <= !pingpong_state;
            end
        end
    end
    // SOF interrupt delayed behind the swap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lead_cnt <= 9'h000;
            lead_busy <= 1'b0;
            sof_irq <= 1'b0;
        end else begin
            sof_irq <= 1'b0;
            if (sof) begin
                lead_busy <= 1'b1;
                lead_cnt <= 9'(SWAP_CYC - 1);
            end else if (lead_busy) begin
                if (lead_cnt == 9'h000) begin
                    lead_busy <= 1'b0;
                    sof_irq <= 1'b1;
                end else begin
                    lead_cnt <= lead_cnt - 9'h001;
                end
            end
        end
    end
    // Zero-count flags, per endpoint; arrival in SOF cycle counts for new frame
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_zc
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    got_bytes[g] <= 1'b0;
                    zero_count_out_flags[g] <= 1'b1;
                end else if (sof) begin
                    zero_count_out_flags[g] <= !got_bytes[g];
                    got_bytes[g] <= out_byte.valid && (out_byte.ep == 3'(g));
                end else if (out_byte.valid && out_byte.ep == 3'(g)) begin
                    got_bytes[g] <= 1'b1;
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // IN tokens on empty FIFOs
    // ----------------------------------------
    // One shared send-empty bit for all iso IN endpoints
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tok_state <= tok_idle;
            send_zlp <= 1'b0;
            zlp_ep <= 3'h0;
        end else begin
            send_zlp <= 1'b0;
            case (tok_state)
                tok_idle: begin
                    if (in_token.valid && !iso_disable && in_fifo_empty[in_token.ep]) begin
                        zlp_ep <= in_token.ep;
                        tok_state <= tok_wait;
                    end
                end
                tok_wait: begin
                    if (endpoint_pairing_control[`PR_SEND_EMPTY]) begin
                        tok_state <= tok_zlp;
                    end else begin
                        tok_state <= tok_idle;
                    end
                end
                tok_zlp: begin
                    send_zlp <= 1'b1;
                    tok_state <= tok_idle;
                end
                default: tok_state <= tok_idle;
            endcase
        end
    end

    // ----------------------------------------
    // CPU memory side and external bus
    // ----------------------------------------
    assign in_strobe_window = in_range(cpu_acc.addr,
        iso_disable ? `STRB_LO_OFF : `STRB_LO_ON, `STRB_LO_END)
        || in_range(cpu_acc.addr, `STRB_HI_LO, 16'hffff);
    // Memory map decode and auto pointer guard
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            iso_ram_as_data <= 1'b0;
            auto_ptr_blocked <= 1'b0;
        end else begin
            iso_ram_as_data <= iso_disable;
            auto_ptr_blocked <= iso_disable
                && in_range(auto_ptr_addr, `ISO_RAM_LO, `ISO_RAM_HI);
        end
    end
    // FIFO load path and strobes, polarity applied to fast strobes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fifo_wdata <= 8'h00;
            fifo_we <= 1'b0;
            ext_data_out <= 8'h00;
            ext_data_oe <= 1'b0;
            fast_read_strobe <= 1'b1;
            fast_write_strobe <= 1'b1;
            ext_rd_strobe <= 1'b1;
            ext_wr_strobe <= 1'b1;
        end else begin
            fifo_we <= 1'b0;
            ext_data_oe <= 1'b0;
            fast_read_strobe <= !rd_pol;
            fast_write_strobe <= !wr_pol;
            ext_rd_strobe <= !(cpu_acc.req && !cpu_acc.wr && in_strobe_window);
            ext_wr_strobe <= !(cpu_acc.req && cpu_acc.wr && in_strobe_window);
            if (cpu_acc.req && cpu_iso_fifo && !iso_disable) begin
                if (cpu_acc.wr && cpu_in_fifo) begin
                    fifo_we <= 1'b1;
                    fifo_wdata <= fast_iso ? ext_data_in : cpu_acc_data;
                    if (fast_iso) begin
                        fast_read_strobe <= rd_pol;
                    end
                end else if (!cpu_acc.wr && fast_iso) begin
                    ext_data_out <= cpu_acc_data;
                    ext_data_oe <= 1'b1;
                    fast_write_strobe <= wr_pol;
                end
            end
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_sof_seen;
        sof;
    endsequence
    property p_pingpong_toggle;
        s_sof_seen |=> pingpong_state != $past(pingpong_state);
    endproperty
    a_pingpong_toggle: assert property (p_pingpong_toggle) else $error("pingpong stuck");
    property p_pingpong_hold;
        !sof |=> $stable(pingpong_state);
    endproperty
    a_pingpong_hold: assert property (p_pingpong_hold) else $error("pingpong moved");
    property p_zero_count_stable;
        !sof |=> $stable(zero_count_out_flags);
    endproperty
    a_zero_count_stable: assert property (p_zero_count_stable) else $error("flags moved");
    property p_zero_count_update;
        sof |=> zero_count_out_flags == ~$past(got_bytes);
    endproperty
    a_zero_count_update: assert property (p_zero_count_update) else $error("flags bad");
    property p_swap_before_irq;
        (sof && !iso_disable) |=> fifo_swap ##[248:250] sof_irq;
    endproperty
    a_swap_before_irq: assert property (p_swap_before_irq) else $error("irq lead wrong");
    property p_no_zlp_when_off;
        (tok_state == tok_wait && !endpoint_pairing_control[`PR_SEND_EMPTY]) |=> ##1 !send_zlp;
    endproperty
    a_no_zlp_when_off: assert property (p_no_zlp_when_off) else $error("zlp sent");
    property p_zlp_when_on;
        (tok_state == tok_wait && endpoint_pairing_control[`PR_SEND_EMPTY]) |=> ##1 send_zlp;
    endproperty
    a_zlp_when_on: assert property (p_zlp_when_on) else $error("zlp missing");
    property p_auto_ptr_guard;
        (iso_disable && in_range(auto_ptr_addr, `ISO_RAM_LO, `ISO_RAM_HI)) |=> auto_ptr_blocked;
    endproperty
    a_auto_ptr_guard: assert property (p_auto_ptr_guard) else $error("ptr not blocked");
    property p_fast_load;
        (cpu_acc.req && cpu_acc.wr && cpu_iso_fifo && cpu_in_fifo && fast_iso && !iso_disable)
        |=> fifo_we && fifo_wdata == $past(ext_data_in);
    endproperty
    a_fast_load: assert property (p_fast_load) else $error("fast load wrong");
    property p_strobe_low_window;
        (iso_disable && cpu_acc.req && !cpu_acc.wr && cpu_acc.addr == `STRB_LO_ON)
        |=> ext_rd_strobe;
    endproperty
    a_strobe_low_window: assert property (p_strobe_low_window) else $error("strobe fired");

endmodule : iso_buffer_control
`default_nettype wire

//--- sim/usb_host_model.sv
// Host and external FIFO model facing the iso buffer control.
// Assumes pclk from the bench and an active-low fast read strobe.
`timescale 1ns/1ps
`default_nettype none
module usb_host_model
    import iso_ctrl_pkg::*;
(
    input wire logic pclk,
    input wire logic fast_read_strobe,
    output logic sof,
    output ep_event_s out_byte,
    output ep_event_s in_token,
    output logic [7:0] ext_data_in
);
    initial begin
        sof = 1'b0;
        out_byte = '0;
        in_token = '0;
        ext_data_in = 8'h5a;
    end

    // External FIFO moves to its next byte after each read strobe
    always @(posedge pclk) begin
        if (fast_read_strobe === 1'b0) begin
            ext_data_in <= ext_data_in * 8'h05 + 8'h3b;
        end
    end

    // One-cycle host event: 0 frame start, 1 OUT byte, 2 IN token; returns mid-cycle after it
    task automatic pulse(input logic [1:0] kind, input logic [2:0] ep);
        @(posedge pclk);
        sof <= (kind == 2'd0);
        out_byte <= {kind == 2'd1, ep};
        in_token <= {kind == 2'd2, ep};
        @(posedge pclk);
        sof <= 1'b0;
        out_byte <= '0;
        in_token <= '0;
        @(negedge pclk);
    endtask : pulse
endmodule : usb_host_model
`default_nettype wire

//--- sim/tb_iso_buffer_control.sv
// Self-checking bench for the iso buffer control.
// Assumes the host model drives frames, tokens and the external bus.
`timescale 1ns/1ps
`default_nettype none
module tb_iso_buffer_control
    import iso_ctrl_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, fifo_we;
    logic sof, ext_data_oe, fast_read_strobe, fast_write_strobe, ext_rd_strobe;
    logic ext_wr_strobe, iso_ram_as_data, auto_ptr_blocked, iso_disable;
    logic pingpong_state, fifo_swap, sof_irq, send_zlp, cpu_iso_fifo, cpu_in_fifo, pp;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, seed;
    logic [7:0] in_fifo_empty, cpu_acc_data, ext_data_in, fifo_wdata, ext_data_out, sent;
    logic [15:0] auto_ptr_addr, lo;
    logic [15:0] sa[7] = '{16'h1fff, 16'h2000, 16'h27ff, 16'h2800, 16'h7b40, 16'h7b41,
        16'hffff};
    logic [7:0] got[3] = '{8'h00, 8'h81, 8'h00};
    logic [2:0] zlp_ep;
    ep_event_s out_byte, in_token;
    cpu_acc_s cpu_acc;
    logic [32:0] rd_q[$];
    logic [7:0] fifo_q[$];
    logic [2:0] zlp_q[$];
    int failures, compares, cycles, n;

    iso_buffer_control i_iso_buffer_control (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .sof, .out_byte, .in_token, .in_fifo_empty, .cpu_acc, .cpu_iso_fifo,
        .cpu_in_fifo, .cpu_acc_data, .ext_data_in, .auto_ptr_addr, .fifo_wdata, .fifo_we,
        .ext_data_out, .ext_data_oe, .fast_read_strobe, .fast_write_strobe, .ext_rd_strobe,
        .ext_wr_strobe, .iso_ram_as_data, .auto_ptr_blocked, .iso_disable, .pingpong_state,
        .fifo_swap, .sof_irq, .send_zlp, .zlp_ep
    );
    usb_host_model i_usb_host_model (
        .pclk, .fast_read_strobe, .sof, .out_byte, .in_token, .ext_data_in
    );

    // 25 MHz clock
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish

    // APB transfer: setup, access held until the edge that samples pready high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(negedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
            @(negedge pclk);
        end
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic err);
        rd_q.push_back({err, exp});
        apb(1'b0, a, 32'h0);
    endtask : rd

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    // One-cycle CPU access; returns mid-cycle while its outputs stand
    task automatic cpu(input logic w, input logic [15:0] a, input logic iso);
        @(posedge pclk);
        sent = seed[7:0];
        cpu_acc <= {1'b1, w, a};
        cpu_iso_fifo <= iso;
        cpu_in_fifo <= iso;
        cpu_acc_data <= sent;
        seed = lfsr(seed);
        @(posedge pclk);
        if (iso && w) fifo_q.push_back(ext_data_in);
        cpu_acc.req <= 1'b0;
        @(negedge pclk);
    endtask : cpu

    // Result watcher and hang limit, sampled mid-cycle
    always @(negedge pclk) begin
        cycles++;
        if (cycles > 8000) begin
            failures++;
            tally_and_finish();
        end
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
            if (rd_q.size() == 0) check(32'h1, 32'h0);
            else begin
                check(pslverr, rd_q[0][32]);
                if (!rd_q[0][32]) check(prdata, rd_q[0][31:0]);
                void'(rd_q.pop_front());
            end
        end
        if (fifo_we === 1'b1) begin
            if (fifo_q.size() == 0) check(32'h1, 32'h0);
            else check(fifo_wdata, fifo_q.pop_front());
        end
        if (send_zlp === 1'b1) begin
            if (zlp_q.size() == 0) check(32'h1, 32'h0);
            else check(zlp_ep, zlp_q.pop_front());
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        cpu_acc = '0;
        cpu_iso_fifo = 1'b0;
        cpu_in_fifo = 1'b0;
        cpu_acc_data = 8'h00;
        in_fifo_empty = 8'hff;
        auto_ptr_addr = 16'h0000;
        seed = 32'h000105b1;
        pp = 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(12'h004, 32'h0, 1'b0);
        rd(12'h008, 32'hff, 1'b0);
        rd(12'h00c, 32'h0, 1'b0);
        rd(12'h014, 32'h0, 1'b1);
        // Empty-packet replies on every endpoint
        wr(12'h00c, 32'h80);
        for (int e = 0; e < 8; e++) begin
            zlp_q.push_back(e[2:0]);
            i_usb_host_model.pulse(2'd2, e[2:0]);
            repeat (5) @(posedge pclk);
        end
        in_fifo_empty <= ~(8'h01 << seed[2:0]);
        i_usb_host_model.pulse(2'd2, seed[2:0]);
        repeat (5) @(posedge pclk);
        in_fifo_empty <= 8'hff;
        // Strobe window, enabled then disabled
        for (int d = 0; d < 2; d++) begin
            wr(12'h004, {31'h0, d[0]});
            lo = d ? 16'h2800 : 16'h2000;
            foreach (sa[i]) begin
                for (int w = 0; w < 2; w++) begin
                    cpu(w[0], sa[i], 1'b0);
                    check(w ? ext_wr_strobe : ext_rd_strobe,
                        !(sa[i] >= lo && sa[i] <= 16'h7b40 || sa[i] >= 16'h8000));
                end
            end
        end
        check(iso_disable, 1'b1);
        check(iso_ram_as_data, 1'b1);
        rd(12'h004, 32'h1, 1'b0);
        i_usb_host_model.pulse(2'd2, seed[2:0]);
        auto_ptr_addr <= 16'h2000 + {5'h0, seed[10:0]};
        repeat (4) @(posedge pclk);
        check(auto_ptr_blocked, 1'b1);
        auto_ptr_addr <= 16'h2800;
        repeat (3) @(posedge pclk);
        check(auto_ptr_blocked, 1'b0);
        wr(12'h004, 32'h8);
        repeat (2) @(negedge pclk);
        check(iso_ram_as_data, 1'b0);
        rd(12'h004, 32'h0, 1'b0);
        wr(12'h00c, 32'h0);
        i_usb_host_model.pulse(2'd2, 3'd7);
        repeat (5) @(posedge pclk);
        // Frames with and without OUT traffic
        got[2] = seed[7:0];
        foreach (got[k]) begin
            for (int e = 0; e < 8; e++) if (got[k][e]) i_usb_host_model.pulse(2'd1, e[2:0]);
            i_usb_host_model.pulse(2'd0, 3'd0);
            pp = ~pp;
            check(fifo_swap, 1'b1);
            check(pingpong_state, pp);
            n = 1;
            while (sof_irq !== 1'b1 && n < 400) begin
                @(negedge pclk);
                n++;
            end
            check(n, 251);
            rd(12'h008, {24'h0, ~got[k]}, 1'b0);
            wr(12'h008, 32'h0);
            rd(12'h008, {24'h0, ~got[k]}, 1'b0);
            rd(12'h004, {28'h0, pp, 3'h0}, 1'b0);
        end
        // Fast iso loads from the external bus, clear of any SOF
        wr(12'h000, 32'h80);
        rd(12'h000, 32'h80, 1'b0);
        check(fast_read_strobe, 1'b1);
        repeat (6) begin
            cpu(1'b1, 16'h7f00, 1'b1);
            check(fast_read_strobe, 1'b0);
        end
        // Fast iso read drives the data bus with a write strobe
        cpu(1'b0, 16'h7f00, 1'b1);
        check(ext_data_oe, 1'b1);
        check(ext_data_out, sent);
        check(fast_write_strobe, 1'b0);
        wr(12'h000, 32'ha0);
        repeat (2) @(negedge pclk);
        check(fast_read_strobe, 1'b0);
        repeat (5) @(posedge pclk);
        check(rd_q.size() + fifo_q.size() + zlp_q.size(), 0);
        tally_and_finish();
    end
endmodule : tb_iso_buffer_control
`default_nettype wire
